// [ufc_map.svh]
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH

// register byte offsets
`define UFC_OFF_MODE 8'h00
`define UFC_OFF_STA 8'h04
`define UFC_OFF_TXDATA 8'h08
`define UFC_OFF_RXDATA 8'h0c
`define UFC_OFF_BAUD 8'h10
`define UFC_OFF_IRQ_STAT 8'h14
`define UFC_OFF_IRQ_MASK 8'h18

// serial_mode_control fields
`define UFC_MODE_STOP 0
`define UFC_MODE_FMT_LO 1
`define UFC_MODE_FMT_HI 2
`define UFC_MODE_RECEIVE_POLARITY_INVERT 4
`define UFC_MODE_ECHO 6
`define UFC_MODE_MASK 16'hb4ff
`define UFC_MODE_RESET 16'h0000

// frame format codes
`define UFC_FMT_8N 2'h0
`define UFC_FMT_8E 2'h1
`define UFC_FMT_8O 2'h2
`define UFC_FMT_9N 2'h3

// serial_status_control fields
`define UFC_STA_TXISEL1 15
`define UFC_STA_TXISEL0 13
`define UFC_STA_BRK 11
`define UFC_STA_TXEN 10
`define UFC_STA_TXBF 9
`define UFC_STA_TX_SHIFTER_EMPTY 8
`define UFC_STA_ADDRESS_DETECT_ENABLE 5
`define UFC_STA_RECEIVER_IDLE_FLAG 4
`define UFC_STA_PARITY_ERROR_FLAG 3
`define UFC_STA_FRAMING_ERROR_FLAG 2
`define UFC_STA_OVERRUN_ERROR_FLAG 1
`define UFC_STA_RX_DATA_AVAILABLE 0
`define UFC_STA_WMASK 16'hece0
`define UFC_STA_RESET 16'h0000

// interrupt status / mask bits
`define UFC_IRQ_TX 0
`define UFC_IRQ_RX 1
`define UFC_IRQ_ERR 2

// timing: 16 ticks per bit, default 115200 baud at 50 MHz
`define UFC_OSR_LAST 4'hf
`define UFC_OSR_MID 4'h7
`define UFC_BAUD_RESET 16'h001a
`define UFC_BREAK_FRAME 14'h2000
`define UFC_BREAK_BITS 4'he

`endif

// [ufc_pkg.sv]
package ufc_pkg;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufc_rx_e;
    typedef enum logic {TX_IDLE, TX_SHIFT} ufc_tx_e;

    typedef struct packed {
        ufc_rx_e st;
        logic [3:0] os;
        logic [3:0] bitn;
        logic [9:0] sh;
        logic [8:0] data;
        logic parity_error_flag;
        logic framing_error_flag;
        logic done;
    } ufc_rx_s;

    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] sta;
        logic [15:0] baud;
        logic [15:0] brg;
        logic [2:0] sync;
        logic filt;
        ufc_tx_e tx_st;
        logic [13:0] tx_sh;
        logic [3:0] tx_left;
        logic [3:0] tx_os;
        logic tx_line;
        logic tx_brk;
        logic [8:0] hold;
        logic hold_v;
        logic [8:0] rx_data;
        logic rx_avail;
        logic parity_error_flag;
        logic framing_error_flag;
        logic overrun_error_flag;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } ufc_top_s;

endpackage : ufc_pkg

// [ufc_rx.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ufc_map.svh"

module ufc_rx (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // line side
    input wire logic tick,
    input wire logic rxd,
    input wire logic [1:0] fmt,
    // received character
    output logic [8:0] rx_data,
    output logic rx_done,
    output logic rx_parity_error_flag,
    output logic rx_framing_error_flag,
    output logic rx_idle
);
    import ufc_pkg::*;

    ufc_rx_s q, d;
    logic [3:0] last_bit;

    // next state of the receiver
    always_comb begin
        d = q;
        d.done = 1'b0;
        last_bit = (fmt == `UFC_FMT_8N) ? 4'h7 : 4'h8;
        if (tick) begin
            unique case (q.st)
                RX_IDLE: begin
                    if (!rxd) begin
                        d.st = RX_START;
                        d.os = 4'h0;
                    end
                end
                RX_START: begin
                    d.os = q.os + 4'h1;
                    if (q.os == `UFC_OSR_MID) begin
                        d.st = rxd ? RX_IDLE : RX_DATA; // glitch drops back
                        d.os = 4'h0;
                        d.bitn = 4'h0;
                    end
                end
                RX_DATA: begin
                    d.os = q.os + 4'h1;
                    if (q.os == `UFC_OSR_LAST) begin
                        d.sh[q.bitn] = rxd;
                        d.bitn = q.bitn + 4'h1;
                        if (q.bitn == last_bit) begin
                            d.st = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    d.os = q.os + 4'h1;
                    if (q.os == `UFC_OSR_LAST) begin
                        d.st = RX_IDLE;
                        d.done = 1'b1;
                        d.framing_error_flag = !rxd;
                        d.data = (fmt == `UFC_FMT_9N) ? q.sh[8:0] : {1'b0, q.sh[7:0]};
                        d.parity_error_flag = ((fmt == `UFC_FMT_8E) && (^q.sh[8:0])) ||
                                 ((fmt == `UFC_FMT_8O) && !(^q.sh[8:0]));
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rx_data = q.data;
    assign rx_done = q.done;
    assign rx_parity_error_flag = q.parity_error_flag;
    assign rx_framing_error_flag = q.framing_error_flag;
    assign rx_idle = (q.st == RX_IDLE);

endmodule : ufc_rx
`default_nettype wire

// [ufc_top.sv]
// How it works
// - format 01 adds an even and 10 an odd parity bit after eight data bits, checked on receive.
// - format 11 sends and receives nine data bits with no parity bit.
// - format 00, the reset value, sends and receives eight data bits with no parity.
// - a set stop-count bit makes the transmitter send two stop bits, a cleared one one.
// - one status and control register holds the transmit and receive controls and flags.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ufc_map.svh"

module ufc_top (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    // axi4-lite write address and data
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // serial line
    input wire logic RX_IN,
    output logic TX_OUT,
    output logic TX_OE,
    // interrupt
    output logic IRQ
);
    import ufc_pkg::*;

    ufc_top_s q, d;
    logic tick;
    logic rx_bit;
    logic [8:0] rx_data;
    logic rx_done;
    logic rx_parity_error_flag;
    logic rx_framing_error_flag;
    logic rx_idle;
    logic [1:0] fmt;
    logic [15:0] sta_rd;
    logic tx_load_ev;
    logic tx_done_ev;
    logic rx_ev;
    logic err_ev;
    logic [2:0] irq_clr;
    logic tx_par;

    // merge a write into a 16-bit register by byte lanes
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb);
        merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction : merge

    // receiver shares the oversample tick
    ufc_rx u_rx (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .tick(tick),
        .rxd(rx_bit),
        .fmt(fmt),
        .rx_data(rx_data),
        .rx_done(rx_done),
        .rx_parity_error_flag(rx_parity_error_flag),
        .rx_framing_error_flag(rx_framing_error_flag),
        .rx_idle(rx_idle)
    );

    // combined status and control view
    always_comb begin
        sta_rd = q.sta & `UFC_STA_WMASK;
        sta_rd[`UFC_STA_TXBF] = q.hold_v;
        sta_rd[`UFC_STA_TX_SHIFTER_EMPTY] = (q.tx_st == TX_IDLE);
        sta_rd[`UFC_STA_RECEIVER_IDLE_FLAG] = rx_idle;
        sta_rd[`UFC_STA_PARITY_ERROR_FLAG] = q.parity_error_flag;
        sta_rd[`UFC_STA_FRAMING_ERROR_FLAG] = q.framing_error_flag;
        sta_rd[`UFC_STA_OVERRUN_ERROR_FLAG] = q.overrun_error_flag;
        sta_rd[`UFC_STA_RX_DATA_AVAILABLE] = q.rx_avail;
    end

    // next state of the whole block
    always_comb begin
        d = q;
        fmt = q.mode[`UFC_MODE_FMT_HI:`UFC_MODE_FMT_LO];
        tick = (q.brg >= q.baud); // a divisor written below the running count ends the period at once
        d.brg = tick ? 16'h0000 : q.brg + 16'h0001;
        tx_load_ev = 1'b0;
        tx_done_ev = 1'b0;
        rx_ev = 1'b0;
        err_ev = 1'b0;
        irq_clr = 3'h0;
        tx_par = (fmt == `UFC_FMT_8O) ? !(^q.hold[7:0]) : ^q.hold[7:0];

        // pin synchroniser: accept a change once stages two and three agree
        d.sync = {q.sync[1:0], RX_IN};
        if (q.sync[1] == q.sync[2]) begin
            d.filt = q.sync[2];
        end
        rx_bit = q.mode[`UFC_MODE_ECHO] ? q.tx_line : (q.filt ^ q.mode[`UFC_MODE_RECEIVE_POLARITY_INVERT]);

        // transmitter
        if (!q.sta[`UFC_STA_TXEN]) begin
            d.tx_st = TX_IDLE; // disable aborts and empties the buffer
            d.hold_v = 1'b0;
            d.tx_line = 1'b1;
        end else if (q.tx_st == TX_IDLE) begin
            if (q.sta[`UFC_STA_BRK]) begin
                d.tx_st = TX_SHIFT;
                d.tx_brk = 1'b1;
                d.tx_sh = `UFC_BREAK_FRAME;
                d.tx_left = `UFC_BREAK_BITS;
                d.tx_os = 4'h0;
                d.tx_line = 1'b0;
            end else if (q.hold_v) begin
                d.tx_st = TX_SHIFT;
                d.tx_brk = 1'b0;
                d.hold_v = 1'b0;
                d.tx_os = 4'h0;
                d.tx_line = 1'b0;
                tx_load_ev = 1'b1;
                unique case (fmt)
                    `UFC_FMT_8N: d.tx_sh = {5'h1f, q.hold[7:0], 1'b0};
                    `UFC_FMT_9N: d.tx_sh = {4'hf, q.hold[8:0], 1'b0};
                    `UFC_FMT_8E, `UFC_FMT_8O: d.tx_sh = {4'hf, tx_par, q.hold[7:0], 1'b0};
                endcase
                d.tx_left = ((fmt == `UFC_FMT_8N) ? 4'ha : 4'hb) + {3'h0, q.mode[`UFC_MODE_STOP]};
            end
        end else if (tick) begin
            d.tx_os = q.tx_os + 4'h1;
            if (q.tx_os == `UFC_OSR_LAST) begin
                if (q.tx_left == 4'h1) begin
                    d.tx_st = TX_IDLE;
                    d.tx_line = 1'b1;
                    tx_done_ev = !q.tx_brk;
                    if (q.tx_brk) begin
                        d.sta[`UFC_STA_BRK] = 1'b0; // break request clears itself
                    end
                end else begin
                    d.tx_sh = {1'b1, q.tx_sh[13:1]};
                    d.tx_line = q.tx_sh[1];
                    d.tx_left = q.tx_left - 4'h1;
                end
            end
        end

        // axi4-lite write channel
        if (S_AXI_AWVALID && q.awready) begin
            d.awready = 1'b0;
            d.aw_got = 1'b1;
            d.waddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && q.wready) begin
            d.wready = 1'b0;
            d.w_got = 1'b1;
            d.wdata = S_AXI_WDATA[15:0];
            d.wstrb = S_AXI_WSTRB[1:0];
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = 2'h0;
            unique case (q.waddr)
                `UFC_OFF_MODE: d.mode = merge(q.mode, q.wdata, q.wstrb) & `UFC_MODE_MASK;
                `UFC_OFF_STA: begin
                    d.sta = merge(q.sta, q.wdata, q.wstrb) & `UFC_STA_WMASK;
                    if (q.wstrb[0] && !q.wdata[`UFC_STA_OVERRUN_ERROR_FLAG]) begin
                        d.overrun_error_flag = 1'b0; // writing zero clears overrun
                    end
                end
                `UFC_OFF_TXDATA: begin
                    if (q.wstrb != 2'h0 && !q.hold_v && q.sta[`UFC_STA_TXEN]) begin
                        d.hold = q.wdata[8:0];
                        d.hold_v = 1'b1;
                    end
                end
                `UFC_OFF_BAUD: d.baud = merge(q.baud, q.wdata, q.wstrb);
                `UFC_OFF_IRQ_STAT: irq_clr = q.wstrb[0] ? q.wdata[2:0] : 3'h0;
                `UFC_OFF_IRQ_MASK: d.irq_mask = q.wstrb[0] ? q.wdata[2:0] : q.irq_mask;
                default: d.bresp = 2'h2;
            endcase
        end
        if (q.bvalid && S_AXI_BREADY) begin
            d.bvalid = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end

        // axi4-lite read channel
        if (S_AXI_ARVALID && q.arready) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = 2'h0;
            d.rdata = 32'h0000_0000;
            unique case (S_AXI_ARADDR)
                `UFC_OFF_MODE: d.rdata[15:0] = q.mode;
                `UFC_OFF_STA: d.rdata[15:0] = sta_rd;
                `UFC_OFF_TXDATA: d.rdata[8:0] = q.hold;
                `UFC_OFF_RXDATA: begin
                    d.rdata[8:0] = q.rx_data;
                    d.rx_avail = 1'b0; // reading takes the character
                end
                `UFC_OFF_BAUD: d.rdata[15:0] = q.baud;
                `UFC_OFF_IRQ_STAT: d.rdata[2:0] = q.irq_stat;
                `UFC_OFF_IRQ_MASK: d.rdata[2:0] = q.irq_mask;
                default: d.rresp = 2'h2;
            endcase
        end
        if (q.rvalid && S_AXI_RREADY) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end

        // received character: address filter, overrun, set wins over read
        if (rx_done && !(q.sta[`UFC_STA_ADDRESS_DETECT_ENABLE] && fmt == `UFC_FMT_9N && !rx_data[8])) begin
            err_ev = rx_parity_error_flag || rx_framing_error_flag;
            if (q.rx_avail && d.rx_avail) begin
                d.overrun_error_flag = 1'b1;
                err_ev = 1'b1;
            end else begin
                d.rx_data = rx_data;
                d.parity_error_flag = rx_parity_error_flag;
                d.framing_error_flag = rx_framing_error_flag;
                d.rx_avail = 1'b1;
                rx_ev = 1'b1;
            end
        end

        // sticky interrupt flags, write one clears, new events win
        d.irq_stat = q.irq_stat & ~irq_clr;
        if ((q.sta[`UFC_STA_TXISEL0] && !q.sta[`UFC_STA_TXISEL1]) ? tx_done_ev : tx_load_ev) begin
            d.irq_stat[`UFC_IRQ_TX] = 1'b1;
        end
        if (rx_ev) begin
            d.irq_stat[`UFC_IRQ_RX] = 1'b1;
        end
        if (err_ev) begin
            d.irq_stat[`UFC_IRQ_ERR] = 1'b1;
        end
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    // state register; reset leaves format 00 and one stop bit
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            q <= '0;
            q.mode <= `UFC_MODE_RESET;
            q.sta <= `UFC_STA_RESET;
            q.baud <= `UFC_BAUD_RESET;
            q.sync <= 3'h7;
            q.filt <= 1'b1;
            q.tx_sh <= 14'h3fff;
            q.tx_line <= 1'b1;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign S_AXI_AWREADY = q.awready;
    assign S_AXI_WREADY = q.wready;
    assign S_AXI_BRESP = q.bresp;
    assign S_AXI_BVALID = q.bvalid;
    assign S_AXI_ARREADY = q.arready;
    assign S_AXI_RDATA = q.rdata;
    assign S_AXI_RRESP = q.rresp;
    assign S_AXI_RVALID = q.rvalid;
    assign TX_OUT = q.tx_line;
    assign TX_OE = q.sta[`UFC_STA_TXEN];
    assign IRQ = q.irq;

endmodule : ufc_top
`default_nettype wire

// [ufc_top_properties.sv]
`timescale 1ns/10ps
`default_nettype none

module ufc_checker (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    // write channels
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // read channels
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // serial line
    input wire logic TX_OUT,
    input wire logic TX_OE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    // read answers come one cycle and write answers two cycles after the take, and stand until accepted
    wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID)
        else $error("write response not two cycles after take");
    wr_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped early");
    rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data not one cycle after take");
    rd_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped early");
    unmapped_read_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h18
        |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0) else $error("unmapped read not refused");
    upper_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0)
        else $error("read data upper half not zero");
    // serial line stays high while disabled and holds each low bit for at least eight cycles
    tx_idle_high_a: assert property (!TX_OE && !$past(TX_OE) |-> TX_OUT)
        else $error("transmit line not idle while disabled");
    low_bit_len_a: assert property ($fell(TX_OUT) |-> !TX_OUT [*8])
        else $error("low bit on transmit line too short");
endmodule : ufc_checker

bind ufc_top ufc_checker u_chk (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .TX_OUT(TX_OUT), .TX_OE(TX_OE)
);
`default_nettype wire

// [ufc_node.sv]
`timescale 1ns/10ps
`default_nettype none

module ufc_node #(
    parameter int BIT_CYC = 32
) (
    // clock
    input wire logic clk,
    // serial line
    input wire logic line_in,
    output logic line_out
);
    // line rests at the idle mark between frames
    initial line_out = 1'b1;

    // drive a frame lsb first, start bit at index 0
    task automatic send(input logic [13:0] f, input int n);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            line_out <= f[i];
            repeat (BIT_CYC) @(posedge clk);
        end
        line_out <= 1'b1;
    endtask : send

    // wait for a start bit, then sample each bit near its middle
    task automatic grab(output logic [13:0] f, input int n);
        f = '1;
        @(posedge clk);
        while (line_in) @(posedge clk);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            f[i] = line_in;
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask : grab
endmodule : ufc_node
`default_nettype wire

// [ufc_testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ufc_map.svh"

module testbench;
    localparam int BIT_CYC = 32; // baud register 1 gives 16 ticks of 2 cycles
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, tx_out, tx_oe, irq, rx_line;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [13:0] v, g;
    int n;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;

    // free-running clock
    always #10 clk = ~clk;

    ufc_top dut (
        .SYS_CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h3), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .RX_IN(rx_line), .TX_OUT(tx_out), .TX_OE(tx_oe), .IRQ(irq)
    );
    ufc_node #(.BIT_CYC(BIT_CYC)) node (.clk(clk), .line_in(tx_out), .line_out(rx_line));

    // verdict and end of run
    task automatic tally_and_finish();
        if (miscompares == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one register write: address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [15:0] dat, output logic [1:0] rsp);
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0, dat};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rsp = bresp;
        bready <= 1'b0;
    endtask : wr

    // one register read
    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        dat = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : rd

    // poll one status bit until it reaches a value
    task automatic wait_sta(input int b, input logic val);
        do rd(`UFC_OFF_STA, d, r); while (d[b] !== val);
    endtask : wait_sta

    // expected line bits of a frame, start at index 0, unused high bits at the idle mark
    function automatic logic [13:0] frm(input logic [8:0] dat, input logic [1:0] f, input logic s, output int len);
        logic [13:0] x;
        x = {5'h1f, dat[7:0], 1'b0};
        if (f == 2'h3) x[9] = dat[8];
        else if (f != 2'h0) x[9] = ^dat[7:0] ^ (f == 2'h2);
        len = (f == 2'h0 ? 10 : 11) + s;
        return x;
    endfunction : frm

    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd(`UFC_OFF_MODE, d, r);
        chk(d, 32'h0);
        rd(`UFC_OFF_BAUD, d, r);
        chk(d, 32'h1a);
        rd(8'h1c, d, r);
        chk({30'h0, r}, 32'h2);
        wr(8'h1c, 16'hffff, r);
        chk({30'h0, r}, 32'h2);
        wr(`UFC_OFF_BAUD, 16'h0001, r);
        wr(`UFC_OFF_STA, 16'h2400, r);
        rd(`UFC_OFF_STA, d, r);
        chk(d & 32'hece0, 32'h2400);
        chk({31'h0, tx_oe}, 32'h1);
        // every format code with one and two stop bits, both directions
        for (int k = 0; k < 8; k++) begin
            wr(`UFC_OFF_MODE, {13'h0, k[2:0]}, r);
            v = frm(9'h1a5 ^ k[8:0], k[2:1], k[0], n);
            fork
                node.grab(g, n);
                wr(`UFC_OFF_TXDATA, {7'h0, 9'h1a5 ^ k[8:0]}, r);
            join
            chk({18'h0, g}, {18'h0, v});
            wait_sta(`UFC_STA_TX_SHIFTER_EMPTY, 1'b1);
            node.send(v ^ (k == 5 ? 14'h200 : 14'h0), n);
            wait_sta(`UFC_STA_RX_DATA_AVAILABLE, 1'b1);
            if (k < 6) chk({31'h0, d[`UFC_STA_PARITY_ERROR_FLAG]}, {31'h0, k == 5});
            chk({31'h0, d[`UFC_STA_FRAMING_ERROR_FLAG]}, 32'h0);
            rd(`UFC_OFF_RXDATA, d, r);
            chk(d, (32'h1a5 ^ k) & (k > 5 ? 32'h1ff : 32'hff));
        end
        // interrupt masked, then unmasked, then cleared
        chk({31'h0, irq}, 32'h0);
        wr(`UFC_OFF_IRQ_MASK, 16'h0002, r);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(`UFC_OFF_IRQ_STAT, 16'h0007, r);
        rd(`UFC_OFF_IRQ_STAT, d, r);
        chk(d, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // break: start bit, twelve low bits and one stop bit, then the request clears itself
        fork
            node.grab(g, 14);
            wr(`UFC_OFF_STA, 16'h2c00, r);
        join
        chk({18'h0, g}, 32'h2000);
        wait_sta(`UFC_STA_BRK, 1'b0);
        chk(d & 32'hece0, 32'h2400);
        // internal echo returns the sent character to the receiver
        wr(`UFC_OFF_MODE, 16'h0040, r);
        wr(`UFC_OFF_TXDATA, 16'h003c, r);
        wait_sta(`UFC_STA_RX_DATA_AVAILABLE, 1'b1);
        rd(`UFC_OFF_RXDATA, d, r);
        chk(d, 32'h3c);
        chk({31'h0, irq}, 32'h1);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
